// file: hdl/timed_access_pkg.sv
// Constants for the timed write protection unit
// Notes on behaviour
// - 0xAA write starts three-cycle watch for 0x55
// - 0x55 within watch opens four-cycle window
// - Late 0x55 opens no window
// - Protected writes only land while window open
// - Window self-closes; new unlock needed afterwards
// - Write completing after close changes nothing
// - In-time write lands, later one discarded
// - Reads are never gated
// - Key: 8-bit write-only at 0xC7, resets zero
// - Watchdog and brown-out controls are protected
package timed_access_pkg;
	localparam logic [7:0] KEY_ADDR      = 8'hc7; // Key register address
	localparam logic [7:0] KEY_RESET     = 8'h00; // Key register reset value
	localparam logic [7:0] KEY_FIRST     = 8'haa; // First unlock byte
	localparam logic [7:0] KEY_SECOND    = 8'h55; // Second unlock byte
	localparam logic [7:0] WDOG_ADDR     = 8'hd8; // Watchdog control address
	localparam logic [7:0] BOD_ADDR      = 8'ha3; // Brown-out control address
	localparam logic [7:0] WDOG_RESET    = 8'h00; // Watchdog control reset value
	localparam logic [7:0] BOD_RESET     = 8'h00; // Brown-out control reset value
	localparam int         CNT_W         = 3;     // Width of the cycle counters
	localparam logic [2:0] WATCH_CYCLES  = 3'h3;  // Cycles to wait for second byte
	localparam logic [2:0] WINDOW_CYCLES = 3'h4;  // Cycles the window stays open
endpackage : timed_access_pkg

// file: hdl/cycle_window.sv
// Reloadable down-counter giving a registered active flag
`timescale 1ns/1ps
`default_nettype none
module cycle_window #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic         clear,
	input  wire logic [W-1:0] load_val,
	output logic              active
);
	typedef struct packed {
		logic [W-1:0] count;  // Cycles left
		logic         active; // Count is non-zero
	} cw_state_s;

	cw_state_s state_reg; // Registered state
	cw_state_s state_next; // Next state

	// Load wins over clear, clear over counting down
	always_comb begin
		state_next = state_reg;
		if (load) begin
			state_next.count = load_val;
		end else if (clear) begin
			state_next.count = '0;
		end else if (state_reg.count != '0) begin
			state_next.count = state_reg.count - W'(1);
		end
		state_next.active = (state_next.count != '0);
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign active = state_reg.active;
endmodule : cycle_window
`default_nettype wire

// file: hdl/timed_write_protection.sv
// Timed write protection unit guarding critical control registers
`timescale 1ns/1ps
`default_nettype none
module timed_write_protection (
	input  wire logic       MCLK,
	input  wire logic       RST_B,
	input  wire logic       CE,
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	input  wire logic       SFR_WR,
	input  wire logic       SFR_RD,
	output logic      [7:0] SFR_RDATA,
	output logic      [7:0] WDOG_CTRL,
	output logic      [7:0] BOD_CTRL,
	output logic            WINDOW_OPEN,
	output logic            WRITE_DISCARD
);
	typedef struct packed {
		logic [7:0] key;      // Last key byte, never readable
		logic [7:0] wdog;     // Watchdog control contents
		logic [7:0] bod;      // Brown-out control contents
		logic [7:0] rdata;    // Read data
		logic       discard;  // Refused protected write pulse
	} twp_state_s;

	twp_state_s state_reg;  // Registered state
	twp_state_s state_next; // Next state
	logic       rst_meta_n; // Reset synchroniser, first stage
	logic       rst_n;      // Synchronised reset
	logic       watch_act;  // Waiting for the second byte
	logic       win_act;    // Permission window open
	logic       key_wr;     // Write to the key register
	logic       wd_wr;      // Write to watchdog control
	logic       bod_wr;     // Write to brown-out control
	logic       watch_load; // Start the watch period
	logic       watch_clr;  // End the watch period
	logic       win_load;   // Open the window
	logic       refused;    // Protected write arriving outside the window

	// Reset release through two flip-flops
	// Only the second stage feeds the design, so release is clean
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// Address decode of the write strobe
	assign key_wr = SFR_WR && (SFR_ADDR == timed_access_pkg::KEY_ADDR);
	assign wd_wr  = SFR_WR && (SFR_ADDR == timed_access_pkg::WDOG_ADDR);
	assign bod_wr = SFR_WR && (SFR_ADDR == timed_access_pkg::BOD_ADDR);

	// A protected write arriving while the window is shut; the strobe
	// completes on this edge, so an instruction that began inside the
	// window but lands after it has closed is refused here as well
	assign refused = (wd_wr || bod_wr) && !win_act;

	// Unlock sequencing
	// The second byte also ends the watch, so a repeated 0x55 cannot open
	// another window; a fresh 0xaa always restarts the watch, even while
	// a window is already open
	assign watch_load = key_wr && (SFR_WDATA == timed_access_pkg::KEY_FIRST);
	assign win_load   = key_wr && watch_act
		&& (SFR_WDATA == timed_access_pkg::KEY_SECOND);
	assign watch_clr  = key_wr && watch_act && !watch_load;

	// Watch period after the first byte
	cycle_window #(
		.W(timed_access_pkg::CNT_W)
	) u_watch (
		.clk     (MCLK),
		.rst_n   (rst_n),
		.ce      (CE),
		.load    (watch_load),
		.clear   (watch_clr),
		.load_val(timed_access_pkg::WATCH_CYCLES),
		.active  (watch_act)
	);

	// Permission window, closes on its own
	// No clear: once open, the window always runs its full four cycles
	cycle_window #(
		.W(timed_access_pkg::CNT_W)
	) u_window (
		.clk     (MCLK),
		.rst_n   (rst_n),
		.ce      (CE),
		.load    (win_load),
		.clear   (1'b0),
		.load_val(timed_access_pkg::WINDOW_CYCLES),
		.active  (win_act)
	);

	// Register writes, gated protected writes and free reads
	always_comb begin
		state_next         = state_reg;
		state_next.discard = 1'b0;
		// Key byte is kept but never read back
		if (key_wr) begin
			state_next.key = SFR_WDATA;
		end
		// Only a write completing in an open window lands
		if (wd_wr && win_act) begin
			state_next.wdog = SFR_WDATA;
		end
		if (bod_wr && win_act) begin
			state_next.bod = SFR_WDATA;
		end
		// Refused writes raise a one-cycle flag
		if (refused) begin
			state_next.discard = 1'b1;
		end
		// Reads need no unlock; key reads as zero
		// Read data is registered and held until the next read
		if (SFR_RD) begin
			unique case (SFR_ADDR)
				timed_access_pkg::WDOG_ADDR: state_next.rdata = state_reg.wdog;
				timed_access_pkg::BOD_ADDR:  state_next.rdata = state_reg.bod;
				default:                     state_next.rdata = 8'h00;
			endcase
		end
	end

	// State register
	// Key and control register reset values come from the package constants; read data and the flag reset to zero
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= '0;
			state_reg.key  <= timed_access_pkg::KEY_RESET;
			state_reg.wdog <= timed_access_pkg::WDOG_RESET;
			state_reg.bod  <= timed_access_pkg::BOD_RESET;
		end else if (CE) begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	// The window flag is the flop inside the window counter
	assign SFR_RDATA     = state_reg.rdata;
	assign WDOG_CTRL     = state_reg.wdog;
	assign BOD_CTRL      = state_reg.bod;
	assign WINDOW_OPEN   = win_act;
	assign WRITE_DISCARD = state_reg.discard;

	// Checks other than the freeze ones, sampled only on enabled cycles; a frozen cycle is no cycle
	// for the unlock counters, so the checks skip it as well
	default clocking cb @(posedge MCLK iff CE); endclocking
	default disable iff (!rst_n);

	// Watch period runs three cycles unless a key byte cuts it short
	chk_watch_start: assert property (watch_load ##1 (!key_wr) [*2] |=> watch_act)
		else $error("watch period did not start");
	chk_watch_end: assert property (watch_load ##1 (!key_wr) [*3] |=> !watch_act)
		else $error("watch period ran past three cycles");
	// Watch period starts only on a first key byte
	chk_watch_cause: assert property (!watch_act && !watch_load |=> !watch_act)
		else $error("watch period started by itself");

	// Second byte in time opens the window on the next cycle
	chk_window_open: assert property (win_load |=> win_act)
		else $error("window did not open after second byte");
	// Window never opens without a second byte in time
	chk_window_cause: assert property (!win_act && !win_load |=> !win_act)
		else $error("window opened without unlock");
	// Window stays open four cycles
	chk_window_len: assert property ($rose(win_act) && !win_load |-> win_act [*4])
		else $error("window shorter than four cycles");
	// Window shuts itself right after its four cycles
	chk_window_close: assert property ($rose(win_act) ##0 (!win_load) [*4] |=> !win_act)
		else $error("window stayed open too long");
	// Late second byte opens nothing
	chk_late_second: assert property (key_wr && SFR_WDATA == 8'h55 && !watch_act && !win_act
		|=> !win_act)
		else $error("late second byte opened window");

	// Refused writes change nothing and raise the flag
	chk_gate_closed: assert property ((wd_wr || bod_wr) && !win_act
		|=> $stable(WDOG_CTRL) && $stable(BOD_CTRL) && WRITE_DISCARD)
		else $error("protected write landed outside window");
	// The flag follows a refused write and nothing else
	chk_discard_cause: assert property (WRITE_DISCARD |-> $past(refused))
		else $error("discard flag without refused write");
	// Writes inside the window land
	chk_gate_open: assert property (wd_wr && win_act |=> WDOG_CTRL == $past(SFR_WDATA))
		else $error("protected write lost inside window");
	// Brown-out control lands the same way
	chk_bod_open: assert property (bod_wr && win_act
		|=> BOD_CTRL == $past(SFR_WDATA))
		else $error("brown-out write lost inside window");
	// A stray key byte ends the watch
	chk_abandon_seq: assert property (key_wr && watch_act && SFR_WDATA != 8'h55
		&& SFR_WDATA != 8'haa |=> !watch_act && !$rose(win_act))
		else $error("bad key byte did not abandon sequence");

	// Reads need no unlock
	chk_read_free: assert property (SFR_RD && SFR_ADDR == 8'ha3
		|=> SFR_RDATA == $past(BOD_CTRL))
		else $error("read of brown-out control wrong");
	// Read data stands until the next read
	chk_read_hold: assert property (!SFR_RD |=> $stable(SFR_RDATA))
		else $error("read data changed without a read");
	// The key register reads back as zero
	chk_key_unreadable: assert property (SFR_RD && SFR_ADDR == 8'hc7 |=> SFR_RDATA == 8'h00)
		else $error("key register readable");

	// Clock enable low freezes the window and both protected control registers
	chk_hold_frozen: assert property (@(posedge MCLK) disable iff (!rst_n)
		!CE |=> $stable(WINDOW_OPEN) && $stable(WDOG_CTRL) && $stable(BOD_CTRL))
		else $error("state moved while clock enable was low");

	// Main scenarios: unlock and write, late byte, two writes, refusal, freeze
	cov_unlock: cover property (watch_load ##[1:3] win_load ##1 wd_wr);
	cov_late: cover property (watch_load ##4 (key_wr && SFR_WDATA == 8'h55));
	cov_two_writes: cover property (win_load ##1 wd_wr ##1 bod_wr);
	cov_discard: cover property ($fell(win_act) ##0 bod_wr);
	cov_frozen: cover property (@(posedge MCLK) disable iff (!rst_n)
		win_act && !CE ##1 win_act && CE);
endmodule : timed_write_protection
`default_nettype wire

// file: tb/core_model.sv
// Processor core model issuing key, register writes and reads
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	// Bus quiet at time zero
	initial begin
		{addr, wdata, wr, rd} = '0;
	end
	// One write per call; strobe stands until the next call or idle
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		{addr, wdata, wr, rd} = {a, d, 2'b10};
		@(negedge clk);
	endtask : put
	// Strobes off; stale address and data flip so they carry nothing
	task automatic idle(input int n);
		{wr, rd} = 2'b00;
		addr = ~addr;
		wdata = ~wdata;
		repeat (n) @(negedge clk);
	endtask : idle
	// Key bytes back to back, gap idle cycles between them
	task automatic unlock(input int gap);
		put(timed_access_pkg::KEY_ADDR, timed_access_pkg::KEY_FIRST);
		if (gap > 0) idle(gap);
		put(timed_access_pkg::KEY_ADDR, timed_access_pkg::KEY_SECOND);
	endtask : unlock
	// One read strobe; data taken once settled
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		{addr, wr, rd} = {a, 2'b01};
		@(negedge clk);
		d = rdata;
		rd = 1'b0;
		@(negedge clk);
	endtask : get
endmodule : core_model
`default_nettype wire

// file: tb/timed_write_protection_tb.sv
// Self-checking bench for the timed write protection unit
`timescale 1ns/1ps
`default_nettype none
module timed_write_protection_tb;
	logic       mclk = 1'b0;  // System clock
	logic       rst_b = 1'b0; // Chip reset, active low
	logic [7:0] addr, wdata, rdata, wdog, bod, q, exp;
	logic       wr, rd, win_open, discard;
	logic       ce = 1'b1;    // Clock enable, lowered in one scenario
	int         failures = 0, compares = 0, cycles = 0, win_cnt = 0;
	// Clock, 25 ns period
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	core_model i_core (.clk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	timed_write_protection i_dut (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .SFR_ADDR(addr),
		.SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .WDOG_CTRL(wdog),
		.BOD_CTRL(bod), .WINDOW_OPEN(win_open), .WRITE_DISCARD(discard));
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		compares++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	// Verdict and end of run
	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// Open-window edge count and hang guard
	always @(posedge mclk) begin
		cycles++;
		if (win_open === 1'b1) win_cnt++;
		if (cycles == 2000) begin
			failures++;
			results();
		end
	end
	// Main sequence
	initial begin
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		i_core.idle(3);
		// Reset contents; key and unmapped places read zero
		i_core.get(8'hd8, q);
		chk(q, 8'h00);
		i_core.get(8'ha3, q);
		chk(q, 8'h00);
		i_core.get(8'hc7, q);
		chk(q, 8'h00);
		i_core.get(8'h10, q);
		chk(q, 8'h00);
		// Protected write without unlock is dropped
		i_core.put(8'hd8, 8'hff);
		chk({7'h0, discard}, 8'h01);
		chk(wdog, 8'h00);
		// Second key byte one to four cycles after the first
		for (int g = 0; g < 4; g++) begin
			i_core.unlock(g);
			i_core.put(8'hd8, {6'h08, g[1:0]});
			i_core.idle(5);
			exp = (g < 3) ? {6'h08, g[1:0]} : 8'h22;
			chk(wdog, exp);
		end
		// First and last window edges land, the next is refused
		win_cnt = 0;
		i_core.unlock(0);
		i_core.put(8'hd8, 8'h5a);
		i_core.idle(2);
		i_core.put(8'ha3, 8'h3c);
		i_core.put(8'ha3, 8'hc3);
		chk({7'h0, discard}, 8'h01);
		i_core.idle(3);
		chk(wdog, 8'h5a);
		chk(bod, 8'h3c);
		chk(win_cnt[7:0], 8'h04);
		// Stray key byte abandons the sequence
		i_core.put(8'hc7, 8'haa);
		i_core.put(8'hc7, 8'h12);
		i_core.put(8'hc7, 8'h55);
		i_core.put(8'ha3, 8'h99);
		i_core.idle(2);
		chk(bod, 8'h3c);
		chk({7'h0, win_open}, 8'h00);
		// Reads need no unlock
		i_core.get(8'ha3, q);
		chk(q, 8'h3c);
		i_core.get(8'hd8, q);
		chk(q, 8'h5a);
		// Clock enable low freezes an open window and ignores the bus
		i_core.unlock(0);
		ce = 1'b0;
		i_core.put(8'ha3, 8'h77);
		i_core.idle(5);
		chk({7'h0, win_open}, 8'h01);
		ce = 1'b1;
		i_core.put(8'hd8, 8'h6b);
		i_core.idle(5);
		chk(wdog, 8'h6b);
		chk(bod, 8'h3c);
		chk({7'h0, win_open}, 8'h00);
		// Reset in mid-run restores the reset contents
		rst_b = 1'b0;
		i_core.idle(2);
		chk(wdog, 8'h00);
		chk({7'h0, win_open}, 8'h00);
		rst_b = 1'b1;
		i_core.idle(3);
		i_core.get(8'hd8, q);
		chk(q, 8'h00);
		results();
	end
endmodule : timed_write_protection_tb
`default_nettype wire
